//--- core/ster_encoder.sv
// Self-test sequencer, result encoder and beep generator
`timescale 1ns/1ns
module ster_encoder
  import ster_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic [SW_W-1:0] addressSelectorSwitch,
  input wire logic [RES_W-1:0] subtestFail,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [RES_W-1:0] subtestSelect,
  output logic [2:0] stimulusMode,
  output logic outputDriveEnable,
  output logic beepOut,
  output logic [1:0] baudSelect,
  output logic normalOperation
);
  // stimulusMode: 0 none, 1 vpos, 2 vneg, 3 current/1V limit,
  // 4 high range readback, 5 low range readback
  ster_state_type state;
  logic [SW_W-1:0] swMeta, swSync;
  logic [RES_W-1:0] failMeta, failSync;
  logic [3:0] stepIdx;
  logic [RES_W-1:0] accum;
  logic [RES_W-1:0] resultReg;
  logic instrRun, doneFlag, calibrated;
  logic [RES_W-1:0] errQueue;
  logic [3:0] retryIdx;
  logic [3:0] beepCount;
  logic [3:0] beepLeft;
  logic beepEven, readyBeeped;
  logic [1:0] beepPhase;
  logic [24:0] beepTimer;
  logic busHit, failNow, failRaw;
  logic lowRange;
  logic [RES_W-1:0] failNowVec;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swMeta <= '0;
      swSync <= '0;
      failMeta <= '0;
      failSync <= '0;
    end else if (clockEnable) begin
      swMeta <= addressSelectorSwitch;
      swSync <= swMeta;
      failMeta <= subtestFail;
      failSync <= failMeta;
    end
  end

  always_comb begin
    failNowVec = failSync;
    if (!calibrated) begin
      failNowVec[BIT_NVM] = 1'b1;
    end
  end
  assign failNow = failNowVec[stepIdx];
  // Power-up sees the lines as they are; the uncalibrated memory
  // fault is reported by the test queries only, so a card that is
  // not yet calibrated still reaches the ready state
  assign failRaw = failSync[stepIdx];
  assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic [3:0] beepsFor(input logic [3:0] idx);
    case (idx)
      4'h0: beepsFor = BEEPS_ROM;
      4'h1: beepsFor = BEEPS_RAM;
      4'h2: beepsFor = BEEPS_NVM;
      4'h3: beepsFor = BEEPS_OPT;
      4'h4: beepsFor = BEEPS_POT;
      4'h5: beepsFor = BEEPS_LOOP;
      default: beepsFor = 4'h0;
    endcase
  endfunction

  // Sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_BOOT;
      stepIdx <= '0;
      accum <= '0;
      resultReg <= '0;
      instrRun <= 1'b0;
      lowRange <= 1'b0;
      doneFlag <= 1'b0;
      retryIdx <= '0;
      beepEven <= 1'b0;
      beepCount <= '0;
      readyBeeped <= 1'b0;
      errQueue <= '0;
      normalOperation <= 1'b0;
    end else if (clockEnable) begin
      beepCount <= '0;
      if (busHit && wb_we_i && wb_adr_i == ADDR_ERRQ && wb_sel_i[0]) begin
        errQueue <= '0;
      end
      case (state)
        ST_BOOT: begin
          // Switch synchroniser is still filling after reset; a
          // decision taken now would read its reset value instead
          if (stepIdx != 4'(SYNC_EDGES)) begin
            stepIdx <= stepIdx + 4'h1;
          end else begin
            stepIdx <= '0;
            if (swSync == SW_ALL_ONES) begin
              state <= ST_BYPASS;
            end else begin
              state <= ST_POWERUP;
            end
          end
        end
        ST_POWERUP: begin
          if (failRaw) begin
            errQueue[stepIdx] <= 1'b1;
            retryIdx <= stepIdx;
            beepCount <= beepsFor(stepIdx);
            state <= ST_RETRY;
          end else if (stepIdx == 4'(BIT_POT)) begin
            state <= ST_IDLE;
            normalOperation <= 1'b1;
          end else begin
            stepIdx <= stepIdx + 4'h1;
          end
        end
        ST_RETRY: begin
          if (beepPhase == 2'h0 && beepLeft == 4'h0) begin
            beepCount <= beepsFor(retryIdx);
          end
        end
        ST_BYPASS: begin
          beepEven <= 1'b1;
          if (swSync != SW_ALL_ONES) begin
            beepEven <= 1'b0;
            state <= ST_POWERUP;
            stepIdx <= '0;
          end
        end
        ST_IDLE: begin
          if (!calibrated && !readyBeeped) begin
            // Request is a level; the beeper may still be timing an
            // earlier tone and only takes it when it is free
            beepCount <= BEEPS_READY;
            if (beepPhase != 2'h0) begin
              readyBeeped <= 1'b1;
            end
          end
          if (busHit && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]
              && (wb_dat_i[CTRL_CONF] || wb_dat_i[CTRL_INSTR])) begin
            instrRun <= wb_dat_i[CTRL_INSTR];
            stepIdx <= '0;
            accum <= '0;
            doneFlag <= 1'b0;
            lowRange <= 1'b0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          accum[stepIdx] <= failNow;
          if (failNow) begin
            errQueue[stepIdx] <= 1'b1;
          end
          // In an instrument run the last step runs twice, high then low range
          if (instrRun && stepIdx == 4'(STEP_MAX) && !lowRange) begin
            lowRange <= 1'b1;
          end else if ((!instrRun && stepIdx == 4'(BIT_POT))
              || stepIdx == 4'(STEP_MAX)) begin
            resultReg <= {accum[RES_W-1:1], accum[0]}
                         | (failNow ? (RES_W'(1) << stepIdx) : '0);
            doneFlag <= 1'b1;
            state <= ST_IDLE;
          end else begin
            stepIdx <= stepIdx + 4'h1;
          end
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      subtestSelect <= '0;
      stimulusMode <= '0;
      outputDriveEnable <= 1'b0;
    end else if (clockEnable) begin
      subtestSelect <= '0;
      stimulusMode <= 3'h0;
      outputDriveEnable <= 1'b0;
      if (state == ST_POWERUP || state == ST_RUN) begin
        subtestSelect <= RES_W'(1) << stepIdx;
      end else if (state == ST_RETRY) begin
        subtestSelect <= RES_W'(1) << retryIdx;
      end
      if (state == ST_RUN && instrRun) begin
        case (stepIdx)
          4'h6: stimulusMode <= 3'h1;
          4'h7: stimulusMode <= 3'h2;
          4'h8: stimulusMode <= 3'h3;
          4'h9: stimulusMode <= lowRange ? 3'h5 : 3'h4;
          default: stimulusMode <= 3'h0;
        endcase
        outputDriveEnable <= stepIdx >= 4'(BIT_VMAX);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      beepOut <= 1'b0;
      beepLeft <= '0;
      beepPhase <= 2'h0;
      beepTimer <= '0;
    end else if (clockEnable) begin
      if (beepTimer != '0) begin
        beepTimer <= beepTimer - 25'h1;
      end else if (beepEven) begin
        beepOut <= !beepOut;
        beepTimer <= 25'(BEEP_ON_CYC);
      end else begin
        // Phase 0 waits for a request, 1 sounds a tone, 2 picks
        // the short gap or the long pause after the last tone
        case (beepPhase)
          2'h0: begin
            beepOut <= 1'b0;
            if (beepCount != 4'h0) begin
              beepLeft <= beepCount;
              beepPhase <= 2'h1;
            end
          end
          2'h1: begin
            beepOut <= 1'b1;
            beepLeft <= beepLeft - 4'h1;
            beepTimer <= 25'(BEEP_ON_CYC);
            beepPhase <= 2'h2;
          end
          2'h2: begin
            beepOut <= 1'b0;
            if (beepLeft != 4'h0) begin
              beepTimer <= 25'(BEEP_GAP_CYC);
              beepPhase <= 2'h1;
            end else begin
              beepTimer <= 25'(BEEP_PAUSE_CYC);
              beepPhase <= 2'h0;
            end
          end
          default: beepPhase <= 2'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baudSelect <= BAUD_NONE;
    end else if (clockEnable) begin
      case (swSync)
        SW_BAUD_9K6: baudSelect <= BAUD_9K6;
        SW_BAUD_19K2: baudSelect <= BAUD_19K2;
        SW_BAUD_38K4: baudSelect <= BAUD_38K4;
        default: baudSelect <= BAUD_NONE;
      endcase
    end
  end

  // Wishbone slave, one wait cycle then ack
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      calibrated <= 1'b0;
    end else if (clockEnable) begin
      wb_ack_o <= busHit;
      wb_dat_o <= '0;
      if (busHit && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]
          && wb_dat_i[CTRL_CAL]) begin
        calibrated <= 1'b1;
      end
      if (busHit && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL: wb_dat_o <= {29'h0, calibrated, instrRun, 1'b0};
          ADDR_RESULT: wb_dat_o <= {22'h0, resultReg};
          ADDR_STATUS: wb_dat_o <= {24'h0, baudSelect, normalOperation,
                                    doneFlag, 4'(state)};
          ADDR_ERRQ: wb_dat_o <= {22'h0, errQueue};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule

//--- core/ster_pkg.sv
// Constants for the self-test result encoder
package ster_pkg;
  localparam int CLOCK_HZ = 20000000;
  localparam int BEEP_ON_MS = 100;
  localparam int BEEP_GAP_MS = 150;
  localparam int BEEP_PAUSE_MS = 1000;
  localparam int BEEP_ON_CYC = CLOCK_HZ / 1000 * BEEP_ON_MS;
  localparam int BEEP_GAP_CYC = CLOCK_HZ / 1000 * BEEP_GAP_MS;
  localparam int BEEP_PAUSE_CYC = CLOCK_HZ / 1000 * BEEP_PAUSE_MS;
  localparam int RES_W = 10;
  localparam int SW_W = 5;
  localparam int BIT_ROM = 0;
  localparam int BIT_RAM = 1;
  localparam int BIT_NVM = 2;
  localparam int BIT_OPT = 3;
  localparam int BIT_POT = 4;
  localparam int BIT_LOOP = 5;
  localparam int BIT_VMAX = 6;
  localparam int BIT_VMIN = 7;
  localparam int BIT_QSCALE = 8;
  localparam int BIT_QREAD = 9;
  localparam logic [3:0] BEEPS_ROM = 4'h1;
  localparam logic [3:0] BEEPS_RAM = 4'h1;
  localparam logic [3:0] BEEPS_NVM = 4'h2;
  localparam logic [3:0] BEEPS_OPT = 4'h3;
  localparam logic [3:0] BEEPS_POT = 4'h6;
  localparam logic [3:0] BEEPS_LOOP = 4'h5;
  localparam logic [3:0] BEEPS_READY = 4'h3;
  localparam logic [4:0] SW_ALL_ONES = 5'h1F;
  localparam logic [4:0] SW_BAUD_9K6 = 5'h06;
  localparam logic [4:0] SW_BAUD_19K2 = 5'h01;
  localparam logic [4:0] SW_BAUD_38K4 = 5'h03;
  localparam logic [1:0] BAUD_NONE = 2'h0;
  localparam logic [1:0] BAUD_9K6 = 2'h1;
  localparam logic [1:0] BAUD_19K2 = 2'h2;
  localparam logic [1:0] BAUD_38K4 = 2'h3;
  // Wishbone map, word addresses in byte units
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_ERRQ = 4'hC;
  localparam int CTRL_CONF = 0;
  localparam int CTRL_INSTR = 1;
  localparam int CTRL_CAL = 2;
  localparam int STEP_MAX = 9;
  localparam int SYNC_EDGES = 2;
  typedef enum {
    ST_BOOT, ST_POWERUP, ST_RETRY, ST_BYPASS, ST_IDLE, ST_RUN
  } ster_state_type;
  typedef enum {
    STEP_STAGE, STEP_VPOS, STEP_VNEG, STEP_CURR, STEP_HRNG, STEP_LRNG
  } ster_stage_type;
endpackage

//--- testbench/ster_encoder_monitor.sv
// Checker for the bus handshake, subtest strobes and switch decode
`timescale 1ns/1ns
module ster_encoder_monitor
  import ster_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [SW_W-1:0] addressSelectorSwitch,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [RES_W-1:0] subtestSelect,
  input wire logic outputDriveEnable,
  input wire logic [1:0] baudSelect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Switch held long enough to pass the synchroniser
  property baudMap(logic [4:0] s, logic [1:0] b);
    addressSelectorSwitch == s [*4] |-> baudSelect == b;
  endproperty
  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_quiet_bus: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack on idle bus");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h2 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_select_onehot: assert property ($onehot0(subtestSelect))
    else $error("several subtests selected");
  a_baud_slow: assert property (baudMap(SW_BAUD_9K6, BAUD_9K6))
    else $error("baud decode 9.6k");
  a_baud_mid: assert property (baudMap(SW_BAUD_19K2, BAUD_19K2))
    else $error("baud decode 19.2k");
  a_baud_fast: assert property (baudMap(SW_BAUD_38K4, BAUD_38K4))
    else $error("baud decode 38.4k");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_drive: cover property ($rose(outputDriveEnable));
  c_loop: cover property (subtestSelect[BIT_LOOP]);
endmodule
bind ster_encoder ster_encoder_monitor u_mon (.clock, .rst,
  .addressSelectorSwitch, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .subtestSelect, .outputDriveEnable, .baudSelect);

//--- testbench/ster_subtest_model.sv
// Subtest pass and fail lines seen by the sequencer
`timescale 1ns/1ns
module ster_subtest_model
  import ster_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [RES_W-1:0] failMask,
  output logic [RES_W-1:0] subtestFail
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      subtestFail <= '0;
    end else begin
      subtestFail <= failMask;
    end
  end
endmodule

//--- testbench/tb_ster_encoder.sv
// Testbench for the self-test result encoder
`timescale 1ns/1ns
module tb_ster_encoder import ster_pkg::*; ;
  logic clock = 1'h0, rst = 1'h1, clockEnable = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [SW_W-1:0] addressSelectorSwitch = SW_ALL_ONES;
  logic [RES_W-1:0] subtestFail, subtestSelect, failMask = 10'h0;
  logic [2:0] stimulusMode;
  logic outputDriveEnable, beepOut, normalOperation, wb_ack_o;
  logic driveSeen = 1'h0, clearSeen = 1'h0;
  logic [1:0] baudSelect;
  logic [7:0] modeSeen = 8'h0;
  logic [4:0] swCode [3] = '{SW_BAUD_9K6, SW_BAUD_19K2, SW_BAUD_38K4};
  logic [1:0] baudCode [3] = '{BAUD_9K6, BAUD_19K2, BAUD_38K4};
  int miscompares = 0, checks = 0;
  initial forever #25 clock = ~clock;
  ster_encoder DUT (.clock, .rst, .clockEnable, .addressSelectorSwitch,
    .subtestFail, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .subtestSelect, .stimulusMode,
    .outputDriveEnable, .beepOut, .baudSelect, .normalOperation);
  ster_subtest_model u_model (.clock, .rst, .failMask, .subtestFail);
  // Records output drive and stimulus modes used during a test
  always @(posedge clock) begin
    if (clearSeen) begin
      driveSeen <= 1'h0;
      modeSeen <= 8'h0;
    end else begin
      if (outputDriveEnable) begin
        driveSeen <= 1'h1;
      end
      modeSeen[stimulusMode] <= 1'h1;
    end
  end
  task conclude;
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clock);
    while (wb_ack_o !== 1'h1) @(posedge clock);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task waitIdle;
    repeat (200) begin
      wb(1'h0, ADDR_STATUS, 32'h0);
      if (rd[3:0] === 4'(ST_IDLE)) break;
    end
  endtask
  task runTest(input int b, input logic [9:0] m, input logic [31:0] e);
    failMask <= m;
    clearSeen <= 1'h1;
    repeat (6) @(posedge clock);
    clearSeen <= 1'h0;
    wb(1'h1, ADDR_CTRL, 32'h1 << b);
    waitIdle;
    wb(1'h0, ADDR_RESULT, 32'h0);
    check("result", rd, e);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    wb(1'h0, ADDR_STATUS, 32'h0);
    check("state", rd[3:0], 4'(ST_BYPASS));
    check("normal", normalOperation, 1'h0);
    check("beep", beepOut, 1'h1);
    for (int i = 0; i < 3; i++) begin
      addressSelectorSwitch <= swCode[i];
      repeat (6) @(posedge clock);
      check("baud", baudSelect, baudCode[i]);
    end
    waitIdle;
    check("state", rd[3:0], 4'(ST_IDLE));
    check("normal", normalOperation, 1'h1);
    check("select", subtestSelect, 10'h0);
    wb(1'h0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    runTest(CTRL_CONF, 10'h3FF, 32'h1F);
    check("drive", driveSeen, 1'h0);
    check("mode", modeSeen[5:1], 5'h0);
    wb(1'h0, ADDR_ERRQ, 32'h0);
    check("errq", rd, 32'h1F);
    wb(1'h1, ADDR_ERRQ, 32'h0);
    wb(1'h0, ADDR_ERRQ, 32'h0);
    check("errq", rd, 32'h0);
    runTest(CTRL_CONF, 10'h0, 32'h4);
    wb(1'h1, ADDR_CTRL, 32'h4);
    wb(1'h0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h4);
    runTest(CTRL_CONF, 10'h0, 32'h0);
    runTest(CTRL_INSTR, 10'h0, 32'h0);
    check("mode", modeSeen[5:1], 5'h1F);
    check("drive", driveSeen, 1'h1);
    runTest(CTRL_INSTR, 10'h2A5, 32'h2A5);
    rst <= 1'h1;
    addressSelectorSwitch <= 5'h00;
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    repeat (300) @(posedge clock);
    check("normal", normalOperation, 1'h0);
    check("beep", beepOut, 1'h1);
    check("select", subtestSelect, 10'h001);
    check("baud", baudSelect, BAUD_NONE);
    wb(1'h0, ADDR_STATUS, 32'h0);
    check("state", rd[3:0], 4'(ST_RETRY));
    wb(1'h0, ADDR_ERRQ, 32'h0);
    check("errq", rd, 32'h1);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    conclude;
  end
endmodule
